// ### include/dmadr_pkg.sv
// constants, opcodes and states of the data-move and addressing block
package dmadr_pkg;

	// data and program word width
	localparam int WORD_W = 16;
	// on-chip data RAM: index width and words fitted (144 on the small variant)
	localparam int DADDR_W = 8;
	localparam logic [8:0] RAM_WORDS = 9'h100;
	// program space: address width and words usable for code
	localparam int PADDR_W = 12;
	localparam int PROG_WORDS = 4096;
	localparam int PROG_USABLE_MASKED = 4000;
	localparam int PROG_USABLE_EPROM = 4096;
	// reduced-pin variant: on-chip program ROM only, no table write
	localparam logic REDUCED_PIN = 1'b0;
	// accumulator width and counting bits of an aux register
	localparam int ACC_W = 32;
	localparam int AUX_CNT_W = 9;

	// instruction word fields
	localparam int OPC_HI = 15;
	localparam int OPC_LO = 8;
	localparam int IND_BIT = 7;
	localparam int DIR_HI = 6;
	localparam int MOD_HI = 5;
	localparam int MOD_LO = 4;
	localparam int IMM8_HI = 7;
	localparam int IMM13_HI = 12;
	localparam int PORT_HI = 10;
	localparam int PORT_LO = 8;
	localparam int SEL_BIT = 8;

	// indirect address modify codes
	localparam logic [1:0] MOD_INC = 2'h1;
	localparam logic [1:0] MOD_DEC = 2'h2;

	// opcodes
	localparam logic [7:0] OPC_MOVE_NEXT = 8'h20;
	localparam logic [7:0] OPC_LOAD_MULT_ACC = 8'h21;
	localparam logic [7:0] OPC_SEL_AUX_PTR = 8'h22;
	localparam logic [7:0] OPC_LOAD_PAGE = 8'h23;
	localparam logic [7:0] OPC_LOAD_ACC_IMM = 8'h24;
	localparam logic [6:0] OPC_LOAD_AUX_IMM = 7'h13;
	localparam logic [7:0] OPC_TABLE_READ = 8'h28;
	localparam logic [7:0] OPC_TABLE_WRITE = 8'h29;
	localparam logic [7:0] OPC_BRANCH_AUX = 8'h2A;
	localparam logic [4:0] OPC_PORT_IN = 5'h06;
	localparam logic [4:0] OPC_PORT_OUT = 5'h07;
	localparam logic [2:0] OPC_MULT_IMM = 3'h4;

	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_TBL_WAIT,
		ST_TBL_LAST,
		ST_IO_LAST
	} dmadr_state_t;

	// next aux value after an indirect access
	function automatic logic [WORD_W-1:0] aux_modify(input logic [WORD_W-1:0] aux,
		input logic [1:0] mode);
		logic [WORD_W-1:0] res;
		res = aux;
		if (mode == MOD_INC)
			res = aux + 16'h0001;
		else if (mode == MOD_DEC)
			res = aux - 16'h0001;
		return res;
	endfunction

endpackage

// ### rtl/dmadr_addr_gen.sv
// operand and next-location address forming for direct and indirect modes
module dmadr_addr_gen
	import dmadr_pkg::*;
(
	// instruction and pointers
	input  wire logic [WORD_W-1:0]  instr_i,
	input  wire logic               page_i,
	input  wire logic [WORD_W-1:0]  aux_sel_i,
	// resolved addresses
	output logic [DADDR_W-1:0]      op_addr_o,
	output logic [DADDR_W:0]        next_addr_o
);

	//////////////////////////////////////////////////////////////////////
	// direct: page bit over seven instruction bits; indirect: aux low byte
	wire logic [DADDR_W-1:0] dir_addr;
	wire logic [DADDR_W-1:0] ind_addr;

	assign dir_addr = {page_i, instr_i[DIR_HI:0]}; // RULE5
	assign ind_addr = aux_sel_i[DADDR_W-1:0]; // RULE6
	assign op_addr_o = instr_i[IND_BIT] ? ind_addr : dir_addr;

	// destination of the move is always operand plus one, either mode
	assign next_addr_o = {1'b0, op_addr_o} + 9'h001; // RULE21

endmodule

// ### rtl/dmadr_data_ram.sv
// on-chip data RAM, one combinational read port and one write port
module dmadr_data_ram
	import dmadr_pkg::*;
(
	// clock and reset
	input  wire logic               clock_i,
	input  wire logic               rst_b_i,
	// read port
	input  wire logic [DADDR_W-1:0] rd_addr_i,
	output logic [WORD_W-1:0]       rd_data_o,
	// write port
	input  wire logic               wr_en_i,
	input  wire logic [DADDR_W:0]   wr_addr_i,
	input  wire logic [WORD_W-1:0]  wr_data_i
);

	logic [WORD_W-1:0] mem [256];

	//////////////////////////////////////////////////////////////////////
	// words past the fitted size read zero and ignore writes
	wire logic rd_fitted;
	wire logic wr_fitted;

	assign rd_fitted = {1'b0, rd_addr_i} < RAM_WORDS; // RULE2
	assign wr_fitted = wr_addr_i < RAM_WORDS;
	assign rd_data_o = rd_fitted ? mem[rd_addr_i] : 16'h0000;

	// write port
	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			for (int i = 0; i < 256; i++)
				mem[i] <= 16'h0000;
		end
		else if (wr_en_i && wr_fitted)
			mem[wr_addr_i[DADDR_W-1:0]] <= wr_data_i;
	end

endmodule

// ### rtl/dmadr_top.sv
// data-memory addressing and data-move instruction executor
// Functional notes
// RULE1 - program and data spaces separate; next instruction taken while current executes
// RULE2 - data RAM 16 bits wide, 144 or 256 words; non-immediate operands from it
// RULE3 - non-immediate operands come only from on-chip data RAM
// RULE4 - program space 16-bit words, 4096 addressable, usable count by variant
// RULE5 - direct address is page pointer joined with seven instruction bits
// RULE6 - indirect address is low eight bits of selected aux register
// RULE7 - immediate operand taken from instruction word, no RAM read
// RULE8 - move copies word to next higher address in one cycle, accumulator kept
// RULE9 - combined op loads T, copies to next address, adds product to accumulator
// RULE10 - pointer-select updates aux pointer; page-load updates data page pointer
// RULE11 - accumulator and aux immediate loads take unsigned eight-bit constant
// RULE12 - multiply immediate takes 13-bit signed constant as multiplier operand
// RULE13 - table read moves program word at accumulator address to operand address
// RULE14 - table read takes three machine cycles
// RULE15 - table write moves data word into program memory
// RULE16 - port in and out move words between data RAM and I/O space
// RULE17 - reduced-pin variant has on-chip program ROM only, no external mode
// RULE18 - software on reduced-pin variant must not issue table write
// RULE19 - branch tests selected aux for zero before decrement; nine counting bits
// RULE20 - table program address is low 12 accumulator bits
// RULE21 - move destination is resolved operand address plus one in either mode
module dmadr_top
	import dmadr_pkg::*;
(
	// clock and reset
	input  wire logic               clock_i,
	input  wire logic               rst_b_i,
	// instruction stream
	input  wire logic               instr_valid_i,
	input  wire logic [WORD_W-1:0]  instr_i,
	output logic                    instr_ready_o,
	// multiplier side
	input  wire logic [ACC_W-1:0]   product_i,
	output logic [WORD_W-1:0]       t_reg_o,
	output logic [WORD_W-1:0]       mult_k_o,
	output logic                    mult_k_valid_o,
	// processor state
	output logic [ACC_W-1:0]        acc_o,
	output logic                    aux_ptr_o,
	output logic                    page_o,
	output logic [WORD_W-1:0]       aux0_o,
	output logic [WORD_W-1:0]       aux1_o,
	output logic                    branch_valid_o,
	output logic                    branch_taken_o,
	// program memory
	output logic [PADDR_W-1:0]      prog_addr_o,
	output logic                    prog_rd_o,
	output logic                    prog_wr_o,
	output logic [WORD_W-1:0]       prog_wdata_o,
	input  wire logic [WORD_W-1:0]  prog_rdata_i,
	// I/O port space
	output logic [2:0]              io_addr_o,
	output logic                    io_rd_o,
	output logic                    io_wr_o,
	output logic [WORD_W-1:0]       io_wdata_o,
	input  wire logic [WORD_W-1:0]  io_rdata_i
);

	//////////////////////////////////////////////////////////////////////
	// reset release through two flops
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// architectural registers
	logic [ACC_W-1:0]  acc;
	logic [WORD_W-1:0] t_reg;
	logic [WORD_W-1:0] aux [2];
	logic              aux_ptr;
	logic              page;
	dmadr_state_t      state;
	dmadr_state_t      next_state;
	logic [DADDR_W:0]  held_addr;

	//////////////////////////////////////////////////////////////////////
	// opcode decode
	wire logic [7:0] opc;
	wire logic       take;
	wire logic       is_move;
	wire logic       is_lmacc;
	wire logic       is_selptr;
	wire logic       is_page;
	wire logic       is_lacc;
	wire logic       is_laux;
	wire logic       is_tread;
	wire logic       is_twrite;
	wire logic       is_branch;
	wire logic       is_pin;
	wire logic       is_pout;
	wire logic       is_mulk;
	wire logic       uses_ram;

	assign opc = instr_i[OPC_HI:OPC_LO];
	assign take = instr_valid_i && instr_ready_o; // RULE1
	assign is_mulk = take && (instr_i[15:13] == OPC_MULT_IMM);
	assign is_move = take && (opc == OPC_MOVE_NEXT);
	assign is_lmacc = take && (opc == OPC_LOAD_MULT_ACC);
	assign is_selptr = take && (opc == OPC_SEL_AUX_PTR);
	assign is_page = take && (opc == OPC_LOAD_PAGE);
	assign is_lacc = take && (opc == OPC_LOAD_ACC_IMM);
	assign is_laux = take && (opc[7:1] == OPC_LOAD_AUX_IMM);
	assign is_tread = take && (opc == OPC_TABLE_READ);
	// table write has no target on the reduced-pin part and is dropped
	assign is_twrite = take && (opc == OPC_TABLE_WRITE) && !REDUCED_PIN; // RULE17 RULE18
	assign is_branch = take && (opc == OPC_BRANCH_AUX);
	assign is_pin = take && (opc[7:3] == OPC_PORT_IN);
	assign is_pout = take && (opc[7:3] == OPC_PORT_OUT);
	assign uses_ram = is_move || is_lmacc || is_tread || is_twrite || is_pin || is_pout;

	//////////////////////////////////////////////////////////////////////
	// operand addressing and data RAM
	wire logic [WORD_W-1:0]  aux_sel;
	wire logic [DADDR_W-1:0] op_addr;
	wire logic [DADDR_W:0]   next_addr;
	wire logic [WORD_W-1:0]  operand;
	wire logic               ram_we;
	wire logic [DADDR_W:0]   ram_waddr;
	wire logic [WORD_W-1:0]  ram_wdata;

	assign aux_sel = aux[aux_ptr];

	dmadr_addr_gen u_addr (
		.instr_i     (instr_i),
		.page_i      (page),
		.aux_sel_i   (aux_sel),
		.op_addr_o   (op_addr),
		.next_addr_o (next_addr)
	);

	// every non-immediate operand is read from the on-chip RAM
	dmadr_data_ram u_ram (
		.clock_i   (clock_i),
		.rst_b_i   (rst_n),
		.rd_addr_i (op_addr), // RULE3
		.rd_data_o (operand),
		.wr_en_i   (ram_we),
		.wr_addr_i (ram_waddr),
		.wr_data_i (ram_wdata)
	);

	// write source: next-word copy, table read data or port input data
	wire logic tbl_fill;
	wire logic io_fill;
	logic      prog_rd_pend;

	assign tbl_fill = (state == ST_TBL_LAST) && prog_rd_pend;
	assign io_fill = (state == ST_IO_LAST);
	assign ram_we = is_move || is_lmacc || tbl_fill || io_fill; // RULE8 RULE9
	assign ram_waddr = (tbl_fill || io_fill) ? held_addr : next_addr; // RULE21
	assign ram_wdata = tbl_fill ? prog_rdata_i : (io_fill ? io_rdata_i : operand); // RULE13 RULE16

	//////////////////////////////////////////////////////////////////////
	// immediate fields and aux update
	wire logic [WORD_W-1:0] imm8;
	wire logic [WORD_W-1:0] imm13;
	wire logic              aux_nonzero;
	wire logic [WORD_W-1:0] aux_counted;
	wire logic [WORD_W-1:0] aux_stepped;

	assign imm8 = {8'h00, instr_i[IMM8_HI:0]}; // RULE7 RULE11
	assign imm13 = {{3{instr_i[IMM13_HI]}}, instr_i[IMM13_HI:0]}; // RULE12
	// zero test sees the value before the count moves
	assign aux_nonzero = aux_sel[AUX_CNT_W-1:0] != 9'h000; // RULE19
	assign aux_counted = {aux_sel[WORD_W-1:AUX_CNT_W], aux_sel[AUX_CNT_W-1:0] - 9'h001}; // RULE19
	assign aux_stepped = aux_modify(aux_sel, instr_i[MOD_HI:MOD_LO]);

	//////////////////////////////////////////////////////////////////////
	// sequencer: table ops hold three cycles, port input two
	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
			begin
				if (is_tread || is_twrite)
					next_state = ST_TBL_WAIT; // RULE14
				else if (is_pin)
					next_state = ST_IO_LAST;
			end
			ST_TBL_WAIT: next_state = ST_TBL_LAST;
			ST_TBL_LAST: next_state = ST_IDLE;
			ST_IO_LAST: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	// state, ready and held destination
	always_ff @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			instr_ready_o <= 1'b0;
			held_addr <= 9'h000;
			prog_rd_pend <= 1'b0;
		end
		else
		begin
			state <= next_state;
			instr_ready_o <= (next_state == ST_IDLE);
			if (uses_ram)
				held_addr <= {1'b0, op_addr};
			if (is_tread || is_twrite)
				prog_rd_pend <= is_tread;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// accumulator, T register, pointers
	always_ff @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc <= 32'h00000000;
			t_reg <= 16'h0000;
			aux_ptr <= 1'b0;
			page <= 1'b0;
		end
		else
		begin
			if (is_lmacc)
			begin
				t_reg <= operand; // RULE9
				acc <= acc + product_i; // RULE9
			end
			else if (is_lacc)
				acc <= {16'h0000, imm8}; // RULE11
			if (is_selptr)
				aux_ptr <= instr_i[0]; // RULE10
			if (is_page)
				page <= instr_i[0]; // RULE10
		end
	end

	// aux registers: immediate load, counting, indirect stepping
	always_ff @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aux[0] <= 16'h0000;
			aux[1] <= 16'h0000;
		end
		else if (is_laux)
			aux[instr_i[SEL_BIT]] <= imm8; // RULE11
		else if (is_branch)
			aux[aux_ptr] <= aux_counted; // RULE19
		else if (uses_ram && instr_i[IND_BIT])
			aux[aux_ptr] <= aux_stepped;
	end

	//////////////////////////////////////////////////////////////////////
	// multiplier constant, branch result, program and port requests
	always_ff @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mult_k_o <= 16'h0000;
			mult_k_valid_o <= 1'b0;
			branch_valid_o <= 1'b0;
			branch_taken_o <= 1'b0;
			prog_addr_o <= 12'h000;
			prog_rd_o <= 1'b0;
			prog_wr_o <= 1'b0;
			prog_wdata_o <= 16'h0000;
			io_addr_o <= 3'h0;
			io_rd_o <= 1'b0;
			io_wr_o <= 1'b0;
			io_wdata_o <= 16'h0000;
		end
		else
		begin
			mult_k_valid_o <= is_mulk; // RULE12
			if (is_mulk)
				mult_k_o <= imm13; // RULE12
			branch_valid_o <= is_branch;
			if (is_branch)
				branch_taken_o <= aux_nonzero; // RULE19
			// program memory requests, address from low accumulator bits
			prog_rd_o <= is_tread; // RULE13
			prog_wr_o <= is_twrite; // RULE15
			if (is_tread || is_twrite)
				prog_addr_o <= acc[PADDR_W-1:0]; // RULE20 RULE4
			if (is_twrite)
				prog_wdata_o <= operand; // RULE15
			// port space requests
			io_rd_o <= is_pin; // RULE16
			io_wr_o <= is_pout; // RULE16
			if (is_pin || is_pout)
				io_addr_o <= instr_i[PORT_HI:PORT_LO];
			if (is_pout)
				io_wdata_o <= operand; // RULE16
		end
	end

	//////////////////////////////////////////////////////////////////////
	// state outputs
	always_ff @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_o <= 32'h00000000;
			t_reg_o <= 16'h0000;
			aux_ptr_o <= 1'b0;
			page_o <= 1'b0;
			aux0_o <= 16'h0000;
			aux1_o <= 16'h0000;
		end
		else
		begin
			acc_o <= acc;
			t_reg_o <= t_reg;
			aux_ptr_o <= aux_ptr;
			page_o <= page;
			aux0_o <= aux[0];
			aux1_o <= aux[1];
		end
	end

endmodule

// ### verification/dmadr_ext_mem.sv
// program memory and I/O port model at the far side
module dmadr_ext_mem
	import dmadr_pkg::*;
(
	// clock
	input  wire logic               clock_i,
	// program memory
	input  wire logic [PADDR_W-1:0] prog_addr_i,
	input  wire logic               prog_rd_i,
	input  wire logic               prog_wr_i,
	input  wire logic [WORD_W-1:0]  prog_wdata_i,
	output logic [WORD_W-1:0]       prog_rdata_o,
	// I/O ports
	input  wire logic [2:0]         io_addr_i,
	input  wire logic               io_rd_i,
	output logic [WORD_W-1:0]       io_rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [WORD_W-1:0] mem [PROG_WORDS];
	logic [WORD_W-1:0] churn = 16'h0000;

	// contents follow the address so any read is predictable
	initial for (int i = 0; i < PROG_WORDS; i++) mem[i] = 16'h5000 ^ i[15:0];
	// read answer in the next cycle, a moving pattern otherwise
	always @(posedge clock_i)
	begin
		churn <= churn + 16'h1111;
		prog_rdata_o <= prog_rd_i ? mem[prog_addr_i] : churn;
		if (prog_wr_i && !REDUCED_PIN)
			mem[prog_addr_i] <= prog_wdata_i;
	end
	// port answer only while the read strobe is up
	assign io_rdata_o = io_rd_i ? {8'hC3, 5'h00, io_addr_i} : ~churn;
endmodule

// ### verification/dmadr_top_properties.sv
// assertions on the ports of the data-move and addressing block
module dmadr_top_props
	import dmadr_pkg::*;
(
	// clock and reset
	input  wire logic               clock_i,
	input  wire logic               rst_b_i,
	// instruction stream
	input  wire logic               instr_valid_i,
	input  wire logic [WORD_W-1:0]  instr_i,
	input  wire logic               instr_ready_o,
	// multiplier and accumulator
	input  wire logic [WORD_W-1:0]  mult_k_o,
	input  wire logic               mult_k_valid_o,
	input  wire logic [ACC_W-1:0]   acc_o,
	// program memory and I/O
	input  wire logic [PADDR_W-1:0] prog_addr_o,
	input  wire logic               prog_rd_o,
	input  wire logic               prog_wr_o,
	input  wire logic [2:0]         io_addr_o,
	input  wire logic               io_rd_o,
	input  wire logic               io_wr_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);

	////////////////////////////////////////////////////////////////////////////////
	// multiplier constant is the sign-extended field of the taken word
	a_mult_k_value: assert property (mult_k_valid_o |-> $past(instr_i[15:13]) == OPC_MULT_IMM
		&& mult_k_o == {{3{$past(instr_i[12])}}, $past(instr_i[12:0])})
		else $error("multiplier constant wrong");
	// table read holds the stream off for exactly two cycles
	a_table_len: assert property (prog_rd_o |-> !instr_ready_o ##1 !instr_ready_o ##1 instr_ready_o)
		else $error("table read length wrong");
	a_read_addr: assert property (prog_rd_o |-> prog_addr_o == acc_o[PADDR_W-1:0])
		else $error("table read address wrong");
	a_write_addr: assert property (prog_wr_o |-> prog_addr_o == acc_o[PADDR_W-1:0])
		else $error("table write address wrong");
	a_read_cause: assert property (prog_rd_o |-> $past(instr_valid_i)
		&& $past(instr_i[15:8]) == OPC_TABLE_READ)
		else $error("program read without table read");
	a_write_cause: assert property (prog_wr_o |-> !REDUCED_PIN
		&& $past(instr_i[15:8]) == OPC_TABLE_WRITE)
		else $error("program write without table write");
	// port strobes carry the port field of the word taken just before
	a_in_port: assert property (io_rd_o |-> !instr_ready_o && $past(instr_i[15:11]) == OPC_PORT_IN
		&& io_addr_o == $past(instr_i[PORT_HI:PORT_LO]))
		else $error("port input strobe wrong");
	a_out_port: assert property (io_wr_o |-> $past(instr_i[15:11]) == OPC_PORT_OUT
		&& io_addr_o == $past(instr_i[PORT_HI:PORT_LO]))
		else $error("port output strobe wrong");
endmodule

// ### verification/dmadr_top_test.sv
// self-checking testbench of the data-move and addressing block
module dmadr_top_test
	import dmadr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic               clock_i = 1'b0;
	logic               rst_b_i = 1'b0;
	logic               instr_valid_i = 1'b0;
	logic [WORD_W-1:0]  instr_i = 16'h0000;
	logic [ACC_W-1:0]   product_i = 32'h0001F123;
	logic               instr_ready_o, mult_k_valid_o, aux_ptr_o, page_o;
	logic               branch_valid_o, branch_taken_o, prog_rd_o, prog_wr_o, io_rd_o, io_wr_o;
	logic [WORD_W-1:0]  t_reg_o, mult_k_o, aux0_o, aux1_o, prog_wdata_o, prog_rdata_i;
	logic [WORD_W-1:0]  io_wdata_o, io_rdata_i;
	logic [ACC_W-1:0]   acc_o;
	logic [PADDR_W-1:0] prog_addr_o;
	logic [2:0]         io_addr_o;
	int                 n_mismatch = 0;
	int                 comparisons = 0;
	time                t0;

	dmadr_top u_dut (.clock_i, .rst_b_i, .instr_valid_i, .instr_i, .instr_ready_o, .product_i,
		.t_reg_o, .mult_k_o, .mult_k_valid_o, .acc_o, .aux_ptr_o, .page_o, .aux0_o, .aux1_o,
		.branch_valid_o, .branch_taken_o, .prog_addr_o, .prog_rd_o, .prog_wr_o, .prog_wdata_o,
		.prog_rdata_i, .io_addr_o, .io_rd_o, .io_wr_o, .io_wdata_o, .io_rdata_i);
	dmadr_ext_mem u_mem (.clock_i, .prog_addr_i(prog_addr_o), .prog_rd_i(prog_rd_o),
		.prog_wr_i(prog_wr_o), .prog_wdata_i(prog_wdata_o), .prog_rdata_o(prog_rdata_i),
		.io_addr_i(io_addr_o), .io_rd_i(io_rd_o), .io_rdata_o(io_rdata_i));

	////////////////////////////////////////////////////////////////////////////////
	// clock, 50 ns period
	always #25 clock_i = ~clock_i;

	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// hold the word until an edge with ready high takes it
	task issue(input logic [15:0] w);
		instr_i = w;
		do @(negedge clock_i); while (instr_ready_o !== 1'b1);
		@(posedge clock_i);
		#1;
	endtask
	// nop for one cycle so state outputs catch up
	task quiet;
		instr_i = 16'h0000;
		@(posedge clock_i);
		#1;
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task t_imm;
		issue(16'h2301);
		issue(16'h24A5);
		issue(16'h2685);
		issue(16'h273C);
		issue(16'h2201);
		quiet();
		chk("acc", 16'h00A5, acc_o[15:0]);
		chk("aux0", 16'h0085, aux0_o);
		chk("aux1", 16'h003C, aux1_o);
		chk("ptr", 16'h0001, 16'(aux_ptr_o));
		chk("page", 16'h0001, 16'(page_o));
		issue(16'h9000);
		chk("k_valid", 16'h0001, 16'(mult_k_valid_o));
		chk("k_neg", 16'hF000, mult_k_o);
		issue(16'h8FFF);
		chk("k_pos", 16'h0FFF, mult_k_o);
		issue(16'h2200);
		$display("test immediate loads done");
	endtask
	// port in to a direct place, read back through the aux pointer
	task t_move;
		issue(16'h3305);
		issue(16'h3D90);
		chk("out_strobe", 16'h0001, 16'(io_wr_o));
		chk("out_port", 16'h0005, 16'(io_addr_o));
		chk("out_word", 16'hC303, io_wdata_o);
		issue(16'h2005);
		issue(16'h3A80);
		chk("moved_word", 16'hC303, io_wdata_o);
		quiet();
		chk("acc_kept", 16'h00A5, acc_o[15:0]);
		chk("aux0_inc", 16'h0086, aux0_o);
		$display("test move done");
	endtask
	task t_lma;
		issue(16'h2190);
		quiet();
		chk("t_reg", 16'hC303, t_reg_o);
		chk("acc_lo", 16'hF1C8, acc_o[15:0]);
		chk("acc_hi", 16'h0001, acc_o[31:16]);
		issue(16'h3A80);
		chk("lma_copy", 16'hC303, io_wdata_o);
		$display("test load move accumulate done");
	endtask
	// upper accumulator bits are ignored, written word reads back
	task t_table;
		issue(16'h2810);
		chk("rd_strobe", 16'h0001, 16'(prog_rd_o));
		chk("rd_addr", 16'h01C8, 16'(prog_addr_o));
		t0 = $time;
		issue(16'h3810);
		chk("rd_cycles", 16'h0003, 16'(($time - t0) / 50));
		chk("rd_word", 16'h51C8, io_wdata_o);
		issue(16'h247B);
		issue(16'h2905);
		chk("wr_strobe", 16'h0001, 16'(prog_wr_o));
		chk("wr_addr", 16'h007B, 16'(prog_addr_o));
		chk("wr_word", 16'hC303, prog_wdata_o);
		issue(16'h2811);
		issue(16'h3811);
		chk("round_trip", 16'hC303, io_wdata_o);
		$display("test table done");
	endtask
	// zero count gives not taken and wraps in nine bits
	task t_branch;
		issue(16'h2201);
		issue(16'h2700);
		issue(16'h2A00);
		chk("br_valid", 16'h0001, 16'(branch_valid_o));
		quiet();
		chk("br_zero", 16'h0000, 16'(branch_taken_o));
		chk("aux1_wrap", 16'h01FF, aux1_o);
		issue(16'h2A00);
		quiet();
		chk("br_nonzero", 16'h0001, 16'(branch_taken_o));
		chk("aux1_dec", 16'h01FE, aux1_o);
		$display("test branch done");
	endtask
	// top RAM word, move past the end dropped, indirect decrement
	task t_edge;
		issue(16'h337F);
		chk("in_strobe", 16'h0001, 16'(io_rd_o));
		chk("in_port", 16'h0003, 16'(io_addr_o));
		issue(16'h207F);
		issue(16'h2200);
		issue(16'h2600);
		issue(16'h38A0);
		chk("no_wrap", 16'h0000, io_wdata_o);
		issue(16'h3880);
		chk("top_word", 16'hC303, io_wdata_o);
		quiet();
		chk("aux0_dec", 16'hFFFF, aux0_o);
		$display("test data RAM edges done");
	endtask
	// reset in mid-run clears state, first word after release is taken
	task t_reset;
		rst_b_i = 1'b0;
		@(posedge clock_i);
		#1;
		chk("rst_ready", 16'h0000, 16'(instr_ready_o));
		chk("rst_aux0", 16'h0000, aux0_o);
		chk("rst_page", 16'h0000, 16'(page_o));
		rst_b_i = 1'b1;
		issue(16'h2201);
		quiet();
		chk("rst_ptr_set", 16'h0001, 16'(aux_ptr_o));
		$display("test mid-run reset done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (2) @(posedge clock_i);
		#1;
		rst_b_i = 1'b1;
		instr_valid_i = 1'b1;
		t_imm();
		t_move();
		t_lma();
		t_table();
		t_branch();
		t_edge();
		t_reset();
		give_verdict();
	end
	// watchdog, far beyond the few dozen cycles of the run
	initial
	begin
		#100000;
		n_mismatch++;
		give_verdict();
	end
endmodule

bind dmadr_top dmadr_top_props u_props (.clock_i, .rst_b_i, .instr_valid_i, .instr_i,
	.instr_ready_o, .mult_k_o, .mult_k_valid_o, .acc_o, .prog_addr_o, .prog_rd_o, .prog_wr_o,
	.io_addr_o, .io_rd_o, .io_wr_o);
